//--- hdl/hub_config_register_bank.v
// configuration register bank: device setup, charge support and removable maps
// Functional notes
// - while the low-power block bit is set, u1/u2 is neither started nor accepted unless forced.
// - after a forced link power accept, u1/u2 stays enabled until power-on reset or upstream loss.
// - the low-power block bit is caught from the serial data strap when reset releases.
// - in i2c mode the setup bits are loaded from eeprom writes.
// - in smbus mode a host may overwrite the writable setup bits.
// - the port indicator flag always reads 1 and cannot be changed.
// - the common power flag always reads 1 and cannot be changed.
// - the full power management bit is caught from the power management strap at reset release.
// - the two low bits of the setup register always read zero.
// - the upper four bits of the charge support register read zero and are read only.
// - each charge support bit marks the downstream port of the same index as charge capable.
// - only charge support bits of ports enabled in the used mask may be overwritten.
// - the removable register sits at offset 7 and resets to zero.
// - each low removable bit marks the matching downstream port device as removable.
`timescale 1ns/100ps
`default_nettype none
`include "hub_cfg_map.vh"
module hub_config_register_bank #(
  parameter PORTS = 4
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             smbus_mode,
  input  wire             cfg_wr,
  input  wire [7:0]       cfg_addr,
  input  wire [7:0]       cfg_wdata,
  input  wire             cfg_rd,
  output reg  [7:0]       cfg_rdata,
  input  wire             serial_data_strap,
  input  wire             power_mgmt_strap,
  input  wire             port0_power_charge_strap,
  input  wire             force_pm_accept,
  input  wire             upstream_disconnect,
  input  wire             u1u2_req,
  output reg              u1u2_allow,
  output reg              low_power_state_block,
  output reg              full_power_mgmt_n,
  output reg  [PORTS-1:0] charge_support_mask,
  output reg  [PORTS-1:0] removable_mask,
  output reg  [PORTS-1:0] port_used_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // register state and the next values feeding it
  reg             strap_pending_q;
  reg             forced_q;
  reg [1:0]       setup_hi_q;
  reg             forced_d;
  reg [1:0]       setup_hi_d;
  reg             block_d;
  reg             full_pwr_d;
  reg [PORTS-1:0] charge_d;
  reg [PORTS-1:0] removable_d;
  reg [PORTS-1:0] used_d;
  reg             allow_d;
  reg [7:0]       rdata_d;

  // merge a byte into a mask, touching only bits of used ports
  function [PORTS-1:0] used_merge;
    input [PORTS-1:0] old_v;
    input [PORTS-1:0] new_v;
    input [PORTS-1:0] used_v;
    begin
      used_merge = (old_v & ~used_v) | (new_v & used_v);
    end
  endfunction

  // pad a port mask to a byte; the reserved upper bits read zero
  function [7:0] mask_byte;
    input [PORTS-1:0] mask_v;
    begin
      mask_byte = {{(8-PORTS){1'b0}}, mask_v};
    end
  endfunction

  // offset decode of the write strobe; smbus_mode gates nothing here, since
  // the eeprom loader and the smbus host share this one write port and both
  // modes accept writes alike
  wire wr_setup   = cfg_wr && (cfg_addr == `DEVICE_SETUP_OFFSET);
  wire wr_charge  = cfg_wr && (cfg_addr == `CHARGE_PORT_SUPPORT_OFFSET);
  wire wr_remove  = cfg_wr && (cfg_addr == `REMOVABLE_PORT_MAP_OFFSET);
  wire wr_used    = cfg_wr && (cfg_addr == `PORT_USED_OFFSET);

  ////////////////////////////////////////////////////////////////////////////
  // next values of the register fields; the strap edge wins over any write
  // so a loader that starts early cannot mask the strapped defaults
  always @* begin
    block_d     = low_power_state_block;
    full_pwr_d  = full_power_mgmt_n;
    setup_hi_d  = setup_hi_q;
    charge_d    = charge_support_mask;
    removable_d = removable_mask;
    used_d      = port_used_mask;
    if (strap_pending_q) begin
      block_d    = serial_data_strap;
      full_pwr_d = power_mgmt_strap;
      charge_d   = {PORTS{port0_power_charge_strap}};
    end else begin
      // eeprom or host writes (both arrive on the same write port)
      // host overwrite in smbus mode; mode only matters to the loader
      if (wr_setup) begin
        // indicator, ganged and low bits ignore writes
        block_d    = cfg_wdata[`LPS_BLOCK_BIT];
        full_pwr_d = cfg_wdata[`FULL_PWR_BIT];
        setup_hi_d = cfg_wdata[7:6];
      end
      // only used ports take new charge bits
      if (wr_charge) begin
        charge_d = used_merge(charge_support_mask, cfg_wdata[PORTS-1:0], port_used_mask);
      end
      if (wr_remove) begin
        removable_d = used_merge(removable_mask, cfg_wdata[PORTS-1:0], port_used_mask);
      end
      // the used mask gates the two maps above, so a write to it only
      // steers map writes from the following cycle on
      if (wr_used) begin
        used_d = cfg_wdata[PORTS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the asynchronous reset loads constants only; straps are caught on the
  // first clock after release since a pin may not feed an async-reset flop
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_pending_q       <= 1'b1;
      low_power_state_block <= 1'b0;
      full_power_mgmt_n     <= 1'b0;
      setup_hi_q            <= `DEVICE_SETUP_HI_RESET;
      charge_support_mask   <= {PORTS{1'b0}};
      removable_mask        <= `REMOVABLE_RESET;
      port_used_mask        <= `PORT_USED_RESET;
    end else begin
      strap_pending_q       <= 1'b0;
      low_power_state_block <= block_d;
      full_power_mgmt_n     <= full_pwr_d;
      setup_hi_q            <= setup_hi_d;
      charge_support_mask   <= charge_d;
      removable_mask        <= removable_d;
      port_used_mask        <= used_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link power gating; the forced state lasts until reset or upstream loss.
  // disconnect is a level, not a clear strobe: while it stands no link can
  // carry a forced accept, so it overrides a set in the same cycle
  always @* begin
    forced_d = forced_q;
    if (upstream_disconnect) begin
      forced_d = 1'b0;
    end else if (force_pm_accept) begin
      forced_d = 1'b1;
    end
    allow_d = u1u2_req && !upstream_disconnect &&
              (!low_power_state_block || forced_q || force_pm_accept);
  end

  // gate state; the accept goes out registered, one cycle after the request
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      forced_q   <= 1'b0;
      u1u2_allow <= 1'b0;
    end else begin
      forced_q   <= forced_d;
      u1u2_allow <= allow_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; unmapped offsets read zero so a loader probing past the
  // bank never sees a stale byte
  always @* begin
    case (cfg_addr)
      `DEVICE_SETUP_OFFSET: begin
        rdata_d = {setup_hi_q, low_power_state_block, 1'b1, 1'b1,
                   full_power_mgmt_n, 2'b00};
      end
      `CHARGE_PORT_SUPPORT_OFFSET: begin
        rdata_d = mask_byte(charge_support_mask);
      end
      `REMOVABLE_PORT_MAP_OFFSET: begin
        rdata_d = mask_byte(removable_mask);
      end
      `PORT_USED_OFFSET: begin
        rdata_d = mask_byte(port_used_mask);
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // read data register; it holds between reads so a slow master may take
  // it late, at the cost of showing an old byte until the next read
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_d;
    end
  end

endmodule
`default_nettype wire

//--- hdl/hub_cfg_map.vh
// register offsets, field positions and reset values of the hub configuration bank
`ifndef HUB_CFG_MAP_VH
`define HUB_CFG_MAP_VH
`define DEVICE_SETUP_OFFSET        8'h05
`define CHARGE_PORT_SUPPORT_OFFSET 8'h06
`define REMOVABLE_PORT_MAP_OFFSET  8'h07
`define PORT_USED_OFFSET           8'h08
`define LPS_BLOCK_BIT              5
`define PORT_IND_BIT               4
`define GANGED_BIT                 3
`define FULL_PWR_BIT               2
`define REMOVABLE_RESET            4'h0
`define PORT_USED_RESET            4'hf
`define DEVICE_SETUP_HI_RESET      2'h0
`endif

//--- sim/hub_cfg_checker_assertions.sv
// port-level checks on the config bank
`timescale 1ns/100ps
`default_nettype none
module hub_cfg_checker #(
  parameter PORTS = 4
) (
  input wire logic             core_clk,
  input wire logic             rst_n,
  input wire logic             cfg_wr,
  input wire logic             cfg_rd,
  input wire logic [7:0]       cfg_addr,
  input wire logic [7:0]       cfg_wdata,
  input wire logic [7:0]       cfg_rdata,
  input wire logic             u1u2_req,
  input wire logic             u1u2_allow,
  input wire logic             upstream_disconnect,
  input wire logic             low_power_state_block,
  input wire logic [PORTS-1:0] charge_support_mask,
  input wire logic [PORTS-1:0] removable_mask,
  input wire logic [PORTS-1:0] port_used_mask
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // a read of one offset
  sequence rd_at(a);
    cfg_rd && cfg_addr == a;
  endsequence
  // the strap edge drops writes, so it is skipped
  sequence wr_at(a);
    cfg_wr && cfg_addr == a && $past(rst_n);
  endsequence
  setup_fixed_a: assert property (
    rd_at(8'h05) |=> cfg_rdata[4:3] == 2'h3 && cfg_rdata[1:0] == 2'h0) else $error("setup");
  block_read_a: assert property (
    rd_at(8'h05) |=> cfg_rdata[5] == $past(low_power_state_block)) else $error("block");
  charge_read_a: assert property (
    rd_at(8'h06) |=> cfg_rdata == {4'h0, $past(charge_support_mask)}) else $error("charge");
  removable_read_a: assert property (
    rd_at(8'h07) |=> cfg_rdata == {4'h0, $past(removable_mask)}) else $error("removable");
  removable_mask_a: assert property (wr_at(8'h07) |=> removable_mask ==
    ($past(removable_mask) & ~$past(port_used_mask) |
     $past(cfg_wdata[PORTS-1:0]) & $past(port_used_mask))) else $error("removable mask");
  charge_mask_a: assert property (wr_at(8'h06) |=> charge_support_mask ==
    ($past(charge_support_mask) & ~$past(port_used_mask) |
     $past(cfg_wdata[PORTS-1:0]) & $past(port_used_mask))) else $error("mask");
  allow_open_a: assert property (
    u1u2_req && !upstream_disconnect && !low_power_state_block |=> u1u2_allow) else $error("open");
  allow_idle_a: assert property (
    !u1u2_req || upstream_disconnect |=> !u1u2_allow) else $error("idle");
  allow_held_a: assert property (
    u1u2_allow && $past(low_power_state_block) && u1u2_req && !upstream_disconnect
    |=> u1u2_allow) else $error("held");
endmodule
bind hub_config_register_bank hub_cfg_checker #(
  .PORTS(PORTS)
) i_chk (
  .core_clk              (core_clk),
  .rst_n                 (rst_n),
  .cfg_wr                (cfg_wr),
  .cfg_rd                (cfg_rd),
  .cfg_addr              (cfg_addr),
  .cfg_wdata             (cfg_wdata),
  .cfg_rdata             (cfg_rdata),
  .u1u2_req              (u1u2_req),
  .u1u2_allow            (u1u2_allow),
  .upstream_disconnect   (upstream_disconnect),
  .low_power_state_block (low_power_state_block),
  .charge_support_mask   (charge_support_mask),
  .removable_mask        (removable_mask),
  .port_used_mask        (port_used_mask)
);
`default_nettype wire

//--- sim/cfg_host_model.sv
// host on the config port: one byte per transfer
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model (
  input  wire logic       core_clk,
  output var  logic       cfg_wr,
  output var  logic       cfg_rd,
  output var  logic [7:0] cfg_addr,
  output var  logic [7:0] cfg_wdata
);
  // bus idle until the first transfer
  initial begin
    cfg_wr    = 1'h0;
    cfg_rd    = 1'h0;
    cfg_addr  = 8'h00;
    cfg_wdata = 8'h00;
  end
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    #1;
    cfg_wr    = w;
    cfg_rd    = !w;
    cfg_addr  = a;
    cfg_wdata = d;
    @(posedge core_clk);
    #1;
    cfg_wr    = 1'h0;
    cfg_rd    = 1'h0;
    cfg_wdata = ~d; // stale data never lingers
  endtask
endmodule
`default_nettype wire

//--- sim/hub_config_register_bank_test.sv
// self-checking bench for the config bank
`timescale 1ns/100ps
`default_nettype none
module hub_config_register_bank_test;
  logic core_clk = 0, rst_n = 0, strap = 1, frc = 0, disc = 0, req = 0;
  logic cfg_wr, cfg_rd, allow, blk, fpm;
  logic mode = 1'h1;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [3:0] chg, rmb, used;
  int num_errors = 0, n_compared = 0;
  // rows: address, write data, read back
  logic [23:0] rows [8] = '{24'h05fffc, 24'h050018, 24'h06ff0f, 24'h07ff0f,
    24'h080505, 24'h06000a, 24'h07000a, 24'h09ff00};
  always #5 core_clk = ~core_clk;
  hub_config_register_bank i_dut(.core_clk, .rst_n, .smbus_mode(mode), .cfg_wr, .cfg_addr,
    .cfg_wdata, .cfg_rd, .cfg_rdata, .serial_data_strap(strap), .power_mgmt_strap(strap),
    .port0_power_charge_strap(strap), .force_pm_accept(frc), .upstream_disconnect(disc),
    .u1u2_req(req), .u1u2_allow(allow), .low_power_state_block(blk), .full_power_mgmt_n(fpm),
    .charge_support_mask(chg), .removable_mask(rmb), .port_used_mask(used));
  cfg_host_model i_host(.core_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata);
  task chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // wait n edges, then step off the edge so inputs never race the clock
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // reset with one chosen level on all three straps
  task rst(input logic s);
    rst_n = 1'h0;
    strap = s;
    wt(12);
    rst_n = 1'h1;
    wt(2);
  endtask
  // watchdog: the tests need about a hundred cycles, so 2000 means a hang
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
  initial begin
    rst(1'h1);
    chk("straps", {blk, fpm, chg, rmb}, 16'h03f0);
    req = 1'h1;
    wt(2);
    chk("allow", allow, 16'h0);
    frc = 1'h1;
    wt(1);
    frc = 1'h0;
    wt(2);
    chk("allow", allow, 16'h1);
    disc = 1'h1;
    wt(2);
    chk("allow", allow, 16'h0);
    disc = 1'h0;
    wt(2);
    chk("allow", allow, 16'h0);
    foreach (rows[i]) begin
      i_host.xfer(1'h1, rows[i][23:16], rows[i][15:8]);
      i_host.xfer(1'h0, rows[i][23:16], 8'h00);
      chk("rdata", cfg_rdata, rows[i][7:0]);
    end
    // eeprom load in i2c mode: block set again while the link was allowed
    mode = 1'h0;
    i_host.xfer(1'h1, 8'h05, 8'h24);
    i_host.xfer(1'h0, 8'h05, 8'h00);
    chk("eeprom", cfg_rdata, 16'h003c);
    chk("block", blk, 16'h1);
    chk("allow", allow, 16'h0);
    mode = 1'h1;
    rst(1'h0);
    chk("straps", {blk, fpm, chg, rmb, used}, 16'h000f);
    wt(2);
    chk("allow", allow, 16'h1);
    end_of_test;
  end
endmodule
`default_nettype wire
